/* File: src/cpuex_pkg.sv */
// Function
// - File-register operands use a 7-bit address covering registers 0 to 127.
// - A destination bit of 0 sends the result to the accumulator and 1 back to the file register.
// - Clearing the accumulator loads zero into it and sets the zero flag.
// - Decrement-and-skip writes file minus one to the destination, turns the next instruction into an idle cycle on a zero result, and leaves the zero flag alone.
// - Increment-and-skip writes file plus one to the destination, turns the next instruction into an idle cycle on a zero result, and leaves the zero flag alone.
// - Plain increment writes file plus one to the destination and updates the zero flag.
// - The unconditional branch loads its 11-bit immediate into the low program counter bits and takes two cycles.
// - The branch takes counter bits 14 to 11 from latch bits 6 to 3 and changes no flag.
// - OR with literal puts accumulator OR immediate into the accumulator and updates the zero flag.
// - OR with file writes accumulator OR file to the destination and updates the zero flag.
// - Direction load copies the accumulator into port A, B or C direction for operand 5, 6 or 7, flags untouched.
// - XOR with literal puts accumulator XOR immediate into the accumulator and updates the zero flag.
// - XOR with file writes accumulator XOR file to the destination and updates the zero flag.
package cpuex_pkg;
    localparam int ADDR_W = 7;
    localparam int PC_W = 15;
    localparam int BR_W = 11;
    localparam int LATCH_LO = 3;
    localparam int LATCH_HI = 6;
    localparam logic [6:0] DIR_A_SEL = 7'h05;
    localparam logic [6:0] DIR_B_SEL = 7'h06;
    localparam logic [6:0] DIR_C_SEL = 7'h07;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] DIR_RST = 8'hFF;
    localparam logic [14:0] PC_RST = 15'h0000;

    typedef enum logic [3:0] {
        CPUEX_NONE,
        CPUEX_DECREMENT_FILE_OP,
        CPUEX_CLEAR_ACCUMULATOR_OP,
        CPUEX_DECREMENT_SKIP_ZERO_OP,
        CPUEX_UNCONDITIONAL_BRANCH_OP,
        CPUEX_INCREMENT_SKIP_ZERO_OP,
        CPUEX_OR_LITERAL_OP,
        CPUEX_INCREMENT_FILE_OP,
        CPUEX_OR_FILE_OP,
        CPUEX_DIRECTION_LOAD_OP,
        CPUEX_XOR_LITERAL_OP,
        CPUEX_XOR_FILE_OP
    } cpuex_op_t;

    typedef struct packed {
        logic valid;
        cpuex_op_t op;
        logic [6:0] faddr;
        logic dest;
        logic [10:0] imm;
    } cpuex_instr_t;

    typedef struct packed {
        logic we;
        logic [6:0] addr;
        logic [7:0] data;
    } cpuex_fwr_t;
endpackage : cpuex_pkg

/* File: src/cpuex_exec.sv */
`timescale 1ns/1ps
`default_nettype none
module cpuex_exec (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire cpuex_pkg::cpuex_instr_t instr_i,
    input wire logic [7:0] fdata_i,
    input wire logic [7:0] latch_i,
    output logic [6:0] faddr_o,
    output cpuex_pkg::cpuex_fwr_t fwr_o,
    output logic [7:0] acc_o,
    output logic zero_o,
    output logic [14:0] pc_o,
    output logic pc_load_o,
    output logic idle_o,
    output logic busy_o,
    output logic [7:0] dir_a_o,
    output logic [7:0] dir_b_o,
    output logic [7:0] dir_c_o
);
    import cpuex_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef enum logic {CPUEX_RUN, CPUEX_FLUSH} cpuex_phase_t;

    typedef struct packed {
        cpuex_phase_t phase;
        cpuex_fwr_t fwr;
        logic [7:0] acc;
        logic zero;
        logic [14:0] pc;
        logic pc_load;
        logic [7:0] dir_a;
        logic [7:0] dir_b;
        logic [7:0] dir_c;
    } cpuex_state_t;

    cpuex_state_t st_ff;
    cpuex_state_t nxt_st;
    logic [7:0] res;
    logic wr_res;
    logic upd_z;

    function automatic logic is_zero(input logic [7:0] v);
        return v == 8'h00;
    endfunction : is_zero

    // ****************************************
    // execute
    // ****************************************
    // operand fetch is combinational; memory answers in the same cycle
    assign faddr_o = instr_i.faddr;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.fwr.we = 1'b0;
        nxt_st.pc_load = 1'b0;
        res = 8'h00;
        wr_res = 1'b0;
        upd_z = 1'b0;
        if (st_ff.phase == CPUEX_FLUSH) begin
            // second cycle: fetched instruction dropped as idle cycle
            nxt_st.phase = CPUEX_RUN;
        end else if (instr_i.valid) begin
            case (instr_i.op)
                CPUEX_DECREMENT_FILE_OP: begin
                    res = fdata_i - 8'h01;
                    wr_res = 1'b1;
                    upd_z = 1'b1;
                end
                CPUEX_INCREMENT_FILE_OP: begin
                    res = fdata_i + 8'h01;
                    wr_res = 1'b1;
                    upd_z = 1'b1;
                end
                CPUEX_DECREMENT_SKIP_ZERO_OP: begin
                    res = fdata_i - 8'h01;
                    wr_res = 1'b1;
                    if (is_zero(res)) begin
                        nxt_st.phase = CPUEX_FLUSH;
                    end
                end
                CPUEX_INCREMENT_SKIP_ZERO_OP: begin
                    res = fdata_i + 8'h01;
                    wr_res = 1'b1;
                    if (is_zero(res)) begin
                        nxt_st.phase = CPUEX_FLUSH;
                    end
                end
                CPUEX_CLEAR_ACCUMULATOR_OP: begin
                    nxt_st.acc = 8'h00;
                    nxt_st.zero = 1'b1;
                end
                CPUEX_OR_LITERAL_OP: begin
                    nxt_st.acc = st_ff.acc | instr_i.imm[7:0];
                    nxt_st.zero = is_zero(nxt_st.acc);
                end
                CPUEX_XOR_LITERAL_OP: begin
                    nxt_st.acc = st_ff.acc ^ instr_i.imm[7:0];
                    nxt_st.zero = is_zero(nxt_st.acc);
                end
                CPUEX_OR_FILE_OP: begin
                    res = st_ff.acc | fdata_i;
                    wr_res = 1'b1;
                    upd_z = 1'b1;
                end
                CPUEX_XOR_FILE_OP: begin
                    res = st_ff.acc ^ fdata_i;
                    wr_res = 1'b1;
                    upd_z = 1'b1;
                end
                CPUEX_DIRECTION_LOAD_OP: begin
                    // other operands ignored, no flag touched
                    case (instr_i.faddr)
                        DIR_A_SEL: nxt_st.dir_a = st_ff.acc;
                        DIR_B_SEL: nxt_st.dir_b = st_ff.acc;
                        DIR_C_SEL: nxt_st.dir_c = st_ff.acc;
                        default: ;
                    endcase
                end
                CPUEX_UNCONDITIONAL_BRANCH_OP: begin
                    nxt_st.pc = {latch_i[LATCH_HI:LATCH_LO],
                                 instr_i.imm};
                    nxt_st.pc_load = 1'b1;
                    nxt_st.phase = CPUEX_FLUSH;
                end
                default: ;
            endcase
            if (wr_res) begin
                if (instr_i.dest) begin
                    nxt_st.fwr.we = 1'b1;
                    nxt_st.fwr.addr = instr_i.faddr;
                    nxt_st.fwr.data = res;
                end else begin
                    nxt_st.acc = res;
                end
            end
            if (upd_z) begin
                nxt_st.zero = is_zero(res);
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st_ff.phase <= CPUEX_RUN;
            st_ff.fwr <= '0;
            st_ff.acc <= ACC_RST;
            st_ff.zero <= 1'b0;
            st_ff.pc <= PC_RST;
            st_ff.pc_load <= 1'b0;
            st_ff.dir_a <= DIR_RST;
            st_ff.dir_b <= DIR_RST;
            st_ff.dir_c <= DIR_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign fwr_o = st_ff.fwr;
    assign acc_o = st_ff.acc;
    assign zero_o = st_ff.zero;
    assign pc_o = st_ff.pc;
    assign pc_load_o = st_ff.pc_load;
    assign idle_o = (st_ff.phase == CPUEX_FLUSH);
    assign busy_o = (st_ff.phase == CPUEX_FLUSH);
    assign dir_a_o = st_ff.dir_a;
    assign dir_b_o = st_ff.dir_b;
    assign dir_c_o = st_ff.dir_c;

    // ****************************************
    // checks
    // ****************************************
    property p_clr;
        @(posedge clk_sys_i) disable iff (rst_i)
        (!idle_o && instr_i.valid && instr_i.op == CPUEX_CLEAR_ACCUMULATOR_OP)
        |=> (acc_o == 8'h00 && zero_o);
    endproperty
    a_clr: assert property (p_clr) else $error("clear failed");

    property p_dsz;
        @(posedge clk_sys_i) disable iff (rst_i)
        (!idle_o && instr_i.valid && instr_i.op == CPUEX_DECREMENT_SKIP_ZERO_OP
         && fdata_i == 8'h01) |=> idle_o ##1 !idle_o;
    endproperty
    a_dsz: assert property (p_dsz) else $error("dec skip wrong");

    property p_isz;
        @(posedge clk_sys_i) disable iff (rst_i)
        (!idle_o && instr_i.valid
         && instr_i.op == CPUEX_INCREMENT_SKIP_ZERO_OP)
        |=> (idle_o == ($past(fdata_i) == 8'hFF)) && $stable(zero_o);
    endproperty
    a_isz: assert property (p_isz) else $error("inc skip wrong");

    property p_inc;
        @(posedge clk_sys_i) disable iff (rst_i)
        (!idle_o && instr_i.valid && instr_i.op == CPUEX_INCREMENT_FILE_OP
         && !instr_i.dest) |=> acc_o == $past(fdata_i) + 8'h01;
    endproperty
    a_inc: assert property (p_inc) else $error("inc wrong");

    property p_br;
        @(posedge clk_sys_i) disable iff (rst_i)
        (!idle_o && instr_i.valid
         && instr_i.op == CPUEX_UNCONDITIONAL_BRANCH_OP)
        |=> pc_load_o && pc_o[10:0] == $past(instr_i.imm) && idle_o;
    endproperty
    a_br: assert property (p_br) else $error("branch wrong");

    property p_brh;
        @(posedge clk_sys_i) disable iff (rst_i)
        (!idle_o && instr_i.valid
         && instr_i.op == CPUEX_UNCONDITIONAL_BRANCH_OP)
        |=> pc_o[14:11] == $past(latch_i[6:3]) && $stable(zero_o);
    endproperty
    a_brh: assert property (p_brh) else $error("pc high wrong");

    property p_orl;
        @(posedge clk_sys_i) disable iff (rst_i)
        (!idle_o && instr_i.valid && instr_i.op == CPUEX_OR_LITERAL_OP)
        |=> acc_o == ($past(acc_o) | $past(instr_i.imm[7:0]))
            && zero_o == (acc_o == 8'h00);
    endproperty
    a_orl: assert property (p_orl) else $error("or lit wrong");

    property p_xfw;
        @(posedge clk_sys_i) disable iff (rst_i)
        (!idle_o && instr_i.valid && instr_i.op == CPUEX_XOR_FILE_OP
         && instr_i.dest) |=> fwr_o.we
            && fwr_o.data == ($past(acc_o) ^ $past(fdata_i));
    endproperty
    a_xfw: assert property (p_xfw) else $error("xor file wrong");

    property p_dir;
        @(posedge clk_sys_i) disable iff (rst_i)
        (!idle_o && instr_i.valid && instr_i.op == CPUEX_DIRECTION_LOAD_OP
         && instr_i.faddr == DIR_B_SEL) |=> dir_b_o == $past(acc_o)
            && $stable(zero_o);
    endproperty
    a_dir: assert property (p_dir) else $error("direction wrong");

    property p_one;
        @(posedge clk_sys_i) disable iff (rst_i)
        (!idle_o && instr_i.valid
         && instr_i.op != CPUEX_UNCONDITIONAL_BRANCH_OP
         && instr_i.op != CPUEX_DECREMENT_SKIP_ZERO_OP
         && instr_i.op != CPUEX_INCREMENT_SKIP_ZERO_OP) |=> !idle_o;
    endproperty
    a_one: assert property (p_one) else $error("extra cycle");

    property p_dsk;
        @(posedge clk_sys_i) disable iff (rst_i)
        (!idle_o && instr_i.valid
         && instr_i.op == CPUEX_DECREMENT_SKIP_ZERO_OP)
        |=> $stable(zero_o) && (idle_o == ($past(fdata_i) == 8'h01));
    endproperty
    a_dsk: assert property (p_dsk) else $error("dec skip flag");

    property p_dec;
        @(posedge clk_sys_i) disable iff (rst_i)
        (!idle_o && instr_i.valid && instr_i.op == CPUEX_DECREMENT_FILE_OP)
        |=> zero_o == ($past(fdata_i) == 8'h01);
    endproperty
    a_dec: assert property (p_dec) else $error("dec flag wrong");

    property p_ifw;
        @(posedge clk_sys_i) disable iff (rst_i)
        (!idle_o && instr_i.valid && instr_i.op == CPUEX_INCREMENT_FILE_OP
         && instr_i.dest)
        |=> fwr_o.we && fwr_o.addr == $past(instr_i.faddr)
            && fwr_o.data == $past(fdata_i) + 8'h01 && $stable(acc_o);
    endproperty
    a_ifw: assert property (p_ifw) else $error("inc file wrong");

    property p_ofw;
        @(posedge clk_sys_i) disable iff (rst_i)
        (!idle_o && instr_i.valid && instr_i.op == CPUEX_OR_FILE_OP
         && instr_i.dest)
        |=> fwr_o.we && fwr_o.data == ($past(acc_o) | $past(fdata_i))
            && zero_o == (fwr_o.data == 8'h00) && $stable(acc_o);
    endproperty
    a_ofw: assert property (p_ofw) else $error("or file wrong");

    property p_xrl;
        @(posedge clk_sys_i) disable iff (rst_i)
        (!idle_o && instr_i.valid && instr_i.op == CPUEX_XOR_LITERAL_OP)
        |=> acc_o == ($past(acc_o) ^ $past(instr_i.imm[7:0]))
            && zero_o == (acc_o == 8'h00);
    endproperty
    a_xrl: assert property (p_xrl) else $error("xor lit wrong");

    property p_xfa;
        @(posedge clk_sys_i) disable iff (rst_i)
        (!idle_o && instr_i.valid && instr_i.op == CPUEX_XOR_FILE_OP
         && !instr_i.dest)
        |=> acc_o == ($past(acc_o) ^ $past(fdata_i)) && !fwr_o.we
            && zero_o == (acc_o == 8'h00);
    endproperty
    a_xfa: assert property (p_xfa) else $error("xor acc wrong");

    // the dropped word must leave no trace at all
    property p_skp;
        @(posedge clk_sys_i) disable iff (rst_i)
        idle_o |=> !idle_o && !fwr_o.we && !pc_load_o
            && $stable(acc_o) && $stable(zero_o);
    endproperty
    a_skp: assert property (p_skp) else $error("idle slot ran");

    property p_drn;
        @(posedge clk_sys_i) disable iff (rst_i)
        (!idle_o && instr_i.valid && instr_i.op == CPUEX_DIRECTION_LOAD_OP
         && instr_i.faddr != DIR_A_SEL && instr_i.faddr != DIR_B_SEL
         && instr_i.faddr != DIR_C_SEL)
        |=> $stable(dir_a_o) && $stable(dir_b_o) && $stable(dir_c_o);
    endproperty
    a_drn: assert property (p_drn) else $error("stray direction");
endmodule : cpuex_exec
`default_nettype wire

/* File: verification/cpuex_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// data memory seen across the file port
// ************************************************************
module cpuex_mem_model
    import cpuex_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic [6:0] faddr_i,
    input wire cpuex_pkg::cpuex_fwr_t fwr_i,
    output logic [7:0] fdata_o
);
    // whole 7-bit space, no mirroring
    logic [7:0] mem [128];

    // read is combinational, so a write lands one edge after fwr shows it
    assign fdata_o = mem[faddr_i];

    always @(posedge clk_sys_i) begin
        if (fwr_i.we === 1'b1) begin
            mem[fwr_i.addr] <= fwr_i.data;
        end
    end
endmodule : cpuex_mem_model
`default_nettype wire

/* File: verification/cpuex_exec_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// bench top
// ************************************************************
module cpuex_exec_tb;
    import cpuex_pkg::*;
    logic clk_sys_i;
    logic rst_i;
    cpuex_instr_t instr_i;
    logic [7:0] fdata_i;
    logic [7:0] latch_i;
    logic [6:0] faddr_o;
    cpuex_fwr_t fwr_o;
    logic [7:0] acc_o, dir_a_o, dir_b_o, dir_c_o;
    logic zero_o, pc_load_o, idle_o, busy_o;
    logic [14:0] pc_o;
    int fail_count;
    int checks;

    cpuex_exec i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .instr_i(instr_i), .fdata_i(fdata_i), .latch_i(latch_i),
        .faddr_o(faddr_o), .fwr_o(fwr_o), .acc_o(acc_o), .zero_o(zero_o),
        .pc_o(pc_o), .pc_load_o(pc_load_o), .idle_o(idle_o),
        .busy_o(busy_o), .dir_a_o(dir_a_o), .dir_b_o(dir_b_o),
        .dir_c_o(dir_c_o));
    cpuex_mem_model i_mem (.clk_sys_i(clk_sys_i), .faddr_i(faddr_o),
        .fwr_i(fwr_o), .fdata_o(fdata_i));

    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task test_done;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    // one instruction per cycle; outputs judged half a cycle after the edge
    task step(input cpuex_op_t op, input logic [6:0] a, input logic d,
              input logic [10:0] imm, input logic [7:0] acc,
              input logic z, input logic idle);
        instr_i = '{op != CPUEX_NONE, op, a, d, imm};
        @(negedge clk_sys_i);
        chk({8'h00, acc_o}, {8'h00, acc});
        chk({15'h0000, zero_o}, {15'h0000, z});
        chk({14'h0000, idle_o, busy_o}, {14'h0000, idle, idle});
    endtask : step

    initial begin
        fail_count = 0;
        checks = 0;
        instr_i = '0;
        latch_i = 8'hA8;
        rst_i = 1'b1;
        repeat (16) @(negedge clk_sys_i);
        rst_i = 1'b0;
        chk({acc_o, 7'h00, zero_o}, 16'h0000);
        chk({dir_a_o, dir_b_o}, 16'hFFFF);
        chk({dir_c_o, 6'h00, pc_load_o, idle_o}, 16'hFF00);
        chk({1'b0, pc_o}, 16'h0000);
        i_mem.mem[7'h7F] = 8'hFF;
        i_mem.mem[7'h10] = 8'h01;
        i_mem.mem[7'h20] = 8'h0F;
        // ********************************************************
        // accumulator and literal ops
        // ********************************************************
        step(CPUEX_OR_LITERAL_OP, 7'h00, 1'b1, 11'h05A,
             8'h5A, 1'b0, 1'b0);
        // upper immediate bits must not reach the 8-bit literal
        step(CPUEX_XOR_LITERAL_OP, 7'h00, 1'b1, 11'h75A,
             8'h00, 1'b1, 1'b0);
        step(CPUEX_OR_LITERAL_OP, 7'h00, 1'b0, 11'h081,
             8'h81, 1'b0, 1'b0);
        step(CPUEX_CLEAR_ACCUMULATOR_OP, 7'h00, 1'b1, 11'h0FF,
             8'h00, 1'b1, 1'b0);
        // ********************************************************
        // file ops; a file op never directly follows a write to its address
        // ********************************************************
        step(CPUEX_INCREMENT_FILE_OP, 7'h10, 1'b1, 11'h000,
             8'h00, 1'b0, 1'b0);
        chk(fwr_o, {1'b1, 7'h10, 8'h02});
        step(CPUEX_INCREMENT_FILE_OP, 7'h7F, 1'b0, 11'h000,
             8'h00, 1'b1, 1'b0);
        chk({15'h0000, fwr_o.we}, 16'h0000);
        chk({9'h000, faddr_o}, 16'h007F);
        step(CPUEX_DECREMENT_FILE_OP, 7'h10, 1'b1, 11'h000,
             8'h00, 1'b0, 1'b0);
        chk(fwr_o, {1'b1, 7'h10, 8'h01});
        step(CPUEX_OR_LITERAL_OP, 7'h00, 1'b0, 11'h040,
             8'h40, 1'b0, 1'b0);
        // ********************************************************
        // skips: zero result flushes the next one, flag kept at 0
        // ********************************************************
        step(CPUEX_DECREMENT_SKIP_ZERO_OP, 7'h10, 1'b1, 11'h000,
             8'h40, 1'b0, 1'b1);
        chk(fwr_o, {1'b1, 7'h10, 8'h00});
        step(CPUEX_XOR_LITERAL_OP, 7'h00, 1'b0, 11'h0FF,
             8'h40, 1'b0, 1'b0);
        step(CPUEX_INCREMENT_SKIP_ZERO_OP, 7'h7F, 1'b0, 11'h000,
             8'h00, 1'b0, 1'b1);
        step(CPUEX_OR_LITERAL_OP, 7'h00, 1'b0, 11'h033,
             8'h00, 1'b0, 1'b0);
        step(CPUEX_INCREMENT_SKIP_ZERO_OP, 7'h20, 1'b0, 11'h000,
             8'h10, 1'b0, 1'b0);
        // ********************************************************
        // OR / XOR with file and direction loads
        // ********************************************************
        step(CPUEX_OR_FILE_OP, 7'h20, 1'b1, 11'h000,
             8'h10, 1'b0, 1'b0);
        chk(fwr_o, {1'b1, 7'h20, 8'h1F});
        step(CPUEX_DIRECTION_LOAD_OP, 7'h05, 1'b0, 11'h000,
             8'h10, 1'b0, 1'b0);
        step(CPUEX_XOR_FILE_OP, 7'h20, 1'b0, 11'h000,
             8'h0F, 1'b0, 1'b0);
        step(CPUEX_DIRECTION_LOAD_OP, 7'h06, 1'b0, 11'h000,
             8'h0F, 1'b0, 1'b0);
        step(CPUEX_XOR_FILE_OP, 7'h20, 1'b1, 11'h000,
             8'h0F, 1'b0, 1'b0);
        chk(fwr_o, {1'b1, 7'h20, 8'h10});
        step(CPUEX_DIRECTION_LOAD_OP, 7'h08, 1'b0, 11'h000,
             8'h0F, 1'b0, 1'b0);
        step(CPUEX_XOR_LITERAL_OP, 7'h00, 1'b0, 11'h00F,
             8'h00, 1'b1, 1'b0);
        step(CPUEX_DIRECTION_LOAD_OP, 7'h07, 1'b0, 11'h000,
             8'h00, 1'b1, 1'b0);
        chk({dir_a_o, dir_b_o}, 16'h100F);
        chk({8'h00, dir_c_o}, 16'h0000);
        // ********************************************************
        // branch: high bits from latch bits 6:3, then one flushed slot
        // ********************************************************
        step(CPUEX_UNCONDITIONAL_BRANCH_OP, 7'h00, 1'b0, 11'h7FF,
             8'h00, 1'b1, 1'b1);
        chk({pc_load_o, pc_o}, {1'b1, 4'h5, 11'h7FF});
        step(CPUEX_OR_LITERAL_OP, 7'h00, 1'b0, 11'h001,
             8'h00, 1'b1, 1'b0);
        chk({15'h0000, pc_load_o}, 16'h0000);
        // ********************************************************
        // reset mid-run while a branch holds the slot idle
        // ********************************************************
        step(CPUEX_UNCONDITIONAL_BRANCH_OP, 7'h00, 1'b0, 11'h123,
             8'h00, 1'b1, 1'b1);
        rst_i = 1'b1;
        instr_i = '0;
        repeat (2) @(negedge clk_sys_i);
        rst_i = 1'b0;
        chk({acc_o, 6'h00, zero_o, idle_o}, 16'h0000);
        chk({dir_a_o, dir_c_o}, 16'hFFFF);
        chk({1'b0, pc_o}, 16'h0000);
        // first word after release must be taken, not dropped
        step(CPUEX_OR_LITERAL_OP, 7'h00, 1'b0, 11'h0C3,
             8'hC3, 1'b0, 1'b0);
        test_done();
    end
endmodule : cpuex_exec_tb
`default_nettype wire
